// ==== common/icsp_pkg.sv ====
// Shared constants and types for the interrupt control, status and proximity block.
// Assumes a single 40 MHz clock domain and a word-aligned AXI4-Lite register map.
`default_nettype none
package icsp_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_RELOAD = 8'h08;
  localparam logic [7:0] ADDR_EVT = 8'h0C;
  localparam logic [7:0] ADDR_EVT_CLR = 8'h10;
  localparam logic [7:0] ADDR_EVT_EN = 8'h14;
  // Control field positions.
  localparam int SS_BIT = 16;
  localparam int HALT_BIT = 14;
  localparam int MULTI_BIT = 12;
  localparam int THR_LSB = 8;
  localparam int POL_LSB = 0;
  localparam int EXT_N = 5;
  // Status field positions.
  localparam int LVL_LSB = 8;
  localparam int ENT_LSB = 0;
  // Event status layout.
  localparam int EVT_W = 7;
  localparam int EVT_PRESENT = 0;
  localparam int EVT_EXPIRE = 1;
  localparam int EVT_EXT_LSB = 2;
  // Reset values.
  localparam logic [31:0] RELOAD_RST = 32'h0000_0000;
  localparam logic [2:0] THR_RST = 3'h0;
  localparam logic [5:0] ENT_RST = 6'h00;
  localparam logic [EVT_W-1:0] EVT_RST = 7'h00;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // An interrupt request from the source-side priority logic.
  typedef struct packed {
    logic valid;
    logic [2:0] level;
    logic [5:0] entry;
  } icsp_req_t;

  // A register write handed from the bus slave to the register file.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } icsp_wr_t;

  // Proximity gate states.
  typedef enum logic [2:0] {
    PX_IDLE = 3'b001,
    PX_COUNT = 3'b010,
    PX_RELEASE = 3'b100
  } icsp_prox_t;
endpackage
`default_nettype wire

// ==== rtl/icsp_prox_timer.sv ====
// Down-counter for the temporal proximity window.
// Assumes load and run come from logic on the same clock.
`default_nettype none
module icsp_prox_timer
  import icsp_pkg::*;
(
  input wire logic ref_clk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic load, // Load the reload value.
  input wire logic [31:0] loadVal, // Reload value.
  input wire logic run, // Count down while high.
  output logic cntZero // Count has reached zero.
);
  logic [31:0] cnt_ff;

  // Load wins over counting so a new trigger always restarts the window.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_ff <= RELOAD_RST;
    end else if (load) begin
      cnt_ff <= loadVal;
    end else if (run && cnt_ff != 32'h0000_0000) begin
      cnt_ff <= cnt_ff - 32'h0000_0001;
    end
  end

  assign cntZero = (cnt_ff == 32'h0000_0000);

  property p_reload_load;
    @(posedge ref_clk) disable iff (srst)
    load |=> cnt_ff == $past(loadVal);
  endproperty
  a_reload_load: assert property (p_reload_load)
    else $error("Timer did not take the reload value.");

  property p_count_down;
    @(posedge ref_clk) disable iff (srst)
    (!load && run && !cntZero) |=> cnt_ff == $past(cnt_ff) - 32'h0000_0001;
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("Timer did not count down by one.");
endmodule
`default_nettype wire

// ==== rtl/icsp_axil_slave.sv ====
// AXI4-Lite slave front end: one write and one read in flight at most.
// Assumes the register file answers reads combinationally in the cycle of rdEn.
`default_nettype none
module icsp_axil_slave
  import icsp_pkg::*;
(
  input wire logic ref_clk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic [7:0] awaddr, // Write address.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  output logic [1:0] bresp, // Write response.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic [7:0] araddr, // Read address.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  output logic wrEn, // One-cycle register write pulse.
  output icsp_wr_t wrReq, // Write address, data and strobes.
  input wire logic wrErr, // Write address is unmapped.
  output logic rdEn, // One-cycle register read pulse.
  output logic [7:0] rdAddr, // Read address.
  input wire logic [31:0] rdData, // Read data from the register file.
  input wire logic rdErr // Read address is unmapped.
);
  logic awHave_ff, wHave_ff;

  // Address and data are caught independently, so either may arrive first.
  assign awready = !awHave_ff && !bvalid;
  assign wready = !wHave_ff && !bvalid;
  assign wrEn = awHave_ff && wHave_ff;
  assign arready = !rvalid;
  assign rdEn = arvalid && arready;
  assign rdAddr = araddr;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      awHave_ff <= 1'b0;
      wHave_ff <= 1'b0;
      wrReq <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHave_ff <= 1'b1;
        wrReq.addr <= awaddr;
      end
      if (wvalid && wready) begin
        wHave_ff <= 1'b1;
        wrReq.data <= wdata;
        wrReq.strb <= wstrb;
      end
      if (wrEn) begin
        awHave_ff <= 1'b0;
        wHave_ff <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrErr ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read data are registered so that rdata stays put while rready is low.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (rdEn) begin
      rvalid <= 1'b1;
      rdata <= rdData;
      rresp <= rdErr ? RESP_SLVERR : RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  property p_bvalid_hold;
    @(posedge ref_clk) disable iff (srst)
    (bvalid && !bready) |=> bvalid && $stable(bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("Write response dropped before it was taken.");
endmodule
`default_nettype wire

// ==== rtl/icsp_top.sv ====
// Interrupt control and status registers with the temporal proximity gate.
// Assumes req comes from same-clock priority logic and holds until coreIrqValid.
// The extLine pins are asynchronous and are synchronised here.
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none

module icsp_top
  import icsp_pkg::*;
(
  input wire logic ref_clk, // System clock, 40 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic [7:0] awaddr, // AXI write address.
  input wire logic awvalid, // AXI write address valid.
  output logic awready, // AXI write address ready.
  input wire logic [31:0] wdata, // AXI write data.
  input wire logic [3:0] wstrb, // AXI write strobes.
  input wire logic wvalid, // AXI write data valid.
  output logic wready, // AXI write data ready.
  output logic [1:0] bresp, // AXI write response.
  output logic bvalid, // AXI write response valid.
  input wire logic bready, // AXI write response ready.
  input wire logic [7:0] araddr, // AXI read address.
  input wire logic arvalid, // AXI read address valid.
  output logic arready, // AXI read address ready.
  output logic [31:0] rdata, // AXI read data.
  output logic [1:0] rresp, // AXI read response.
  output logic rvalid, // AXI read valid.
  input wire logic rready, // AXI read ready.
  input wire icsp_req_t req, // Pending request from priority logic.
  input wire logic debugMode, // Core is in debug exception mode.
  input wire logic [EXT_N-1:0] extLine, // External interrupt pins.
  output logic coreIrqValid_ff, // One-cycle pulse: request presented.
  output logic [2:0] coreLevel_ff, // Presented priority level.
  output logic [5:0] coreEntry_ff, // Presented entry number.
  output logic coreShadow_ff, // Single entry uses the shadow set.
  output logic multiMode_ff, // Multi-entry mode is active.
  output logic [EXT_N-1:0] extEdge_ff, // One-cycle pulse per detected edge.
  output logic irqOut_ff // Level interrupt from event status.
);
  logic ssel_ff, halt_ff, multiSel_ff;
  logic [2:0] thr_ff;
  logic [EXT_N-1:0] pol_ff;
  logic [31:0] reload_ff;
  logic [EVT_W-1:0] evt_ff, evtEn_ff, evtSet;
  logic [EXT_N-1:0] extS1_ff, extS2_ff, extPrev_ff, extEdge;
  logic wrEn, rdEn, wrErr, rdErr, frozen, qual, canPresent;
  logic timerLoad, timerZero, expire;
  logic [7:0] rdAddr;
  logic [31:0] rdData;
  icsp_wr_t wrReq;
  icsp_prox_t pxState_ff;

  icsp_axil_slave icsp_axil_slave_inst (.ref_clk, .srst, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .wrEn, .wrReq, .wrErr, .rdEn, .rdAddr, .rdData, .rdErr);

  icsp_prox_timer icsp_prox_timer_inst (.ref_clk, .srst, .load(timerLoad),
    .loadVal(reload_ff), .run(!frozen), .cntZero(timerZero));

  // Control register; the halt bit only moves while the core sits in debug.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ssel_ff <= 1'b0;
      halt_ff <= 1'b0;
      multiSel_ff <= 1'b0;
      thr_ff <= THR_RST;
      pol_ff <= '0;
    end else if (wrEn && wrReq.addr == ADDR_CTRL) begin
      if (wrReq.strb[2]) begin
        ssel_ff <= wrReq.data[SS_BIT];
      end
      if (wrReq.strb[1]) begin
        if (debugMode) begin
          halt_ff <= wrReq.data[HALT_BIT];
        end
        multiSel_ff <= wrReq.data[MULTI_BIT];
        thr_ff <= wrReq.data[THR_LSB +: 3];
      end
      if (wrReq.strb[0]) begin
        pol_ff <= wrReq.data[POL_LSB +: EXT_N];
      end
    end
  end

  // Reload register honours byte strobes.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reload_ff <= RELOAD_RST;
    end else if (wrEn && wrReq.addr == ADDR_RELOAD) begin
      for (int b = 0; b < 4; b++) begin
        if (wrReq.strb[b]) begin
          reload_ff[8*b +: 8] <= wrReq.data[8*b +: 8];
        end
      end
    end
  end

  // Event enable register.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      evtEn_ff <= EVT_RST;
    end else if (wrEn && wrReq.addr == ADDR_EVT_EN && wrReq.strb[0]) begin
      evtEn_ff <= wrReq.data[EVT_W-1:0];
    end
  end

  // Sticky events; a new event in the clearing cycle survives the clear.
  assign evtSet = {extEdge, expire, canPresent};
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      evt_ff <= EVT_RST;
    end else if (wrEn && wrReq.addr == ADDR_EVT_CLR && wrReq.strb[0]) begin
      evt_ff <= (evt_ff & ~wrReq.data[EVT_W-1:0]) | evtSet;
    end else begin
      evt_ff <= evt_ff | evtSet;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqOut_ff <= 1'b0;
    end else begin
      irqOut_ff <= |(evt_ff & evtEn_ff);
    end
  end

  // Two flops per pin before any edge logic looks at it.
  genvar g;
  generate
    for (g = 0; g < EXT_N; g++) begin : g_ext
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          extS1_ff[g] <= 1'b0;
          extS2_ff[g] <= 1'b0;
          extPrev_ff[g] <= 1'b0;
        end else begin
          extS1_ff[g] <= extLine[g];
          extS2_ff[g] <= extS1_ff[g];
          extPrev_ff[g] <= extS2_ff[g];
        end
      end
      assign extEdge[g] = pol_ff[g] ? (extS2_ff[g] && !extPrev_ff[g])
                                    : (!extS2_ff[g] && extPrev_ff[g]);
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      extEdge_ff <= '0;
    end else begin
      extEdge_ff <= extEdge;
    end
  end

  // Freeze only bites while the core is actually in debug.
  assign frozen = halt_ff && debugMode;
  // Level zero is a disabled source, so it never qualifies.
  assign qual = (thr_ff != 3'h0) && (req.level != 3'h0)
              && (req.level <= thr_ff);
  // The presentation pulse doubles as the acknowledge, so a request is
  // never taken twice in back-to-back cycles.
  assign canPresent = req.valid && !frozen && !coreIrqValid_ff
                    && (!qual || pxState_ff == PX_RELEASE);
  // The request still standing in the presentation cycle is already taken, so it must not
  // reopen the window; otherwise the gate would arm itself with nothing behind it.
  assign timerLoad = (pxState_ff == PX_IDLE) && req.valid && qual && !frozen
                   && !coreIrqValid_ff;
  assign expire = (pxState_ff == PX_COUNT) && timerZero && !frozen;

  // Proximity gate: a qualifying request opens the window, waits, then passes.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pxState_ff <= PX_IDLE;
    end else begin
      unique case (pxState_ff)
        PX_IDLE: begin
          if (timerLoad) begin
            pxState_ff <= PX_COUNT;
          end
        end
        PX_COUNT: begin
          if (expire) begin
            pxState_ff <= PX_RELEASE;
          end
        end
        PX_RELEASE: begin
          if ((canPresent && qual) || thr_ff == 3'h0) begin
            pxState_ff <= PX_IDLE;
          end
        end
        default: begin
          pxState_ff <= PX_IDLE;
        end
      endcase
    end
  end

  // Presented request also feeds the status fields.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      coreIrqValid_ff <= 1'b0;
      coreLevel_ff <= THR_RST;
      coreEntry_ff <= ENT_RST;
    end else begin
      coreIrqValid_ff <= canPresent;
      if (canPresent) begin
        coreLevel_ff <= req.level;
        coreEntry_ff <= req.entry;
      end
    end
  end

  // Mode outputs to the core.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      coreShadow_ff <= 1'b0;
      multiMode_ff <= 1'b0;
    end else begin
      coreShadow_ff <= ssel_ff && !multiSel_ff;
      multiMode_ff <= multiSel_ff;
    end
  end

  // Read mux; unimplemented bits are zero and unknown addresses error out.
  always_comb begin
    rdData = 32'h0000_0000;
    rdErr = 1'b0;
    unique case (rdAddr)
      ADDR_CTRL: begin
        rdData[SS_BIT] = ssel_ff;
        rdData[HALT_BIT] = halt_ff && debugMode;
        rdData[MULTI_BIT] = multiSel_ff;
        rdData[THR_LSB +: 3] = thr_ff;
        rdData[POL_LSB +: EXT_N] = pol_ff;
      end
      ADDR_STAT: begin
        rdData[LVL_LSB +: 3] = coreLevel_ff;
        rdData[ENT_LSB +: 6] = coreEntry_ff;
      end
      ADDR_RELOAD: rdData = reload_ff;
      ADDR_EVT: rdData[EVT_W-1:0] = evt_ff;
      ADDR_EVT_CLR: rdData = 32'h0000_0000;
      ADDR_EVT_EN: rdData[EVT_W-1:0] = evtEn_ff;
      default: rdErr = 1'b1;
    endcase
  end

  assign wrErr = !(wrReq.addr inside {ADDR_CTRL, ADDR_STAT, ADDR_RELOAD,
                                      ADDR_EVT, ADDR_EVT_CLR, ADDR_EVT_EN});

  property p_shadow;
    @(posedge ref_clk) disable iff (srst)
    (ssel_ff && !multiSel_ff) |=> coreShadow_ff;
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("Shadow set not indicated.");
  property p_freeze;
    @(posedge ref_clk) disable iff (srst)
    frozen |=> !coreIrqValid_ff;
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("Request presented while frozen.");
  property p_halt_guard;
    @(posedge ref_clk) disable iff (srst)
    (wrEn && wrReq.addr == ADDR_CTRL && !debugMode) |=> $stable(halt_ff);
  endproperty
  a_halt_guard: assert property (p_halt_guard)
    else $error("Halt bit written outside debug mode.");
  property p_mode;
    @(posedge ref_clk) disable iff (srst)
    $changed(multiSel_ff) |=> multiMode_ff == $past(multiSel_ff);
  endproperty
  a_mode: assert property (p_mode)
    else $error("Mode output does not follow its select bit.");
  property p_hold_qual;
    @(posedge ref_clk) disable iff (srst)
    (req.valid && qual && pxState_ff != PX_RELEASE) |=> !coreIrqValid_ff;
  endproperty
  a_hold_qual: assert property (p_hold_qual)
    else $error("Qualifying request passed the proximity gate.");
  property p_thr_one;
    @(posedge ref_clk) disable iff (srst)
    (thr_ff == 3'h1 && req.valid && req.level > 3'h1 && !frozen && !coreIrqValid_ff)
      |=> coreIrqValid_ff;
  endproperty
  a_thr_one: assert property (p_thr_one)
    else $error("Higher level held back at threshold one.");
  property p_thr_zero;
    @(posedge ref_clk) disable iff (srst)
    (thr_ff == 3'h0) |-> !timerLoad;
  endproperty
  a_thr_zero: assert property (p_thr_zero)
    else $error("Timer triggered while disabled.");

  property p_edge0;
    @(posedge ref_clk) disable iff (srst)
    (pol_ff[0] && extS2_ff[0] && !extPrev_ff[0]) |=> extEdge_ff[0];
  endproperty
  a_edge0: assert property (p_edge0)
    else $error("Rising edge on line 0 missed.");

  property p_status;
    @(posedge ref_clk) disable iff (srst)
    canPresent |=> coreLevel_ff == $past(req.level) && coreEntry_ff == $past(req.entry);
  endproperty
  a_status: assert property (p_status)
    else $error("Status fields do not match the presented request.");

  property p_stat_zero;
    @(posedge ref_clk) disable iff (srst)
    (rdEn && rdAddr == ADDR_STAT) |-> rdData[31:11] == 21'h0 && rdData[7:6] == 2'h0;
  endproperty
  a_stat_zero: assert property (p_stat_zero)
    else $error("Unimplemented status bits not zero.");

  property p_window;
    @(posedge ref_clk) disable iff (srst)
    (pxState_ff == PX_COUNT && !timerZero) |=> pxState_ff != PX_RELEASE;
  endproperty
  a_window: assert property (p_window)
    else $error("Proximity window closed early.");
endmodule
`default_nettype wire

// ==== dv/icsp_core_model.sv ====
// Behavioural model of the priority source and core that face the block.
// Assumes the bench pulses go for one cycle only while no request is pending.
`default_nettype none
module icsp_core_model
  import icsp_pkg::*;
(
  input wire logic ref_clk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic go, // Raise one request.
  input wire logic [2:0] lvl, // Level to request.
  input wire logic [5:0] ent, // Entry to request.
  input wire logic coreIrqValid_ff, // Presentation pulse from the block.
  output var icsp_req_t req // Request, held until presented.
);
  // The request is held until it is presented and dropped on the next edge, so one request
  // never yields two presentations.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      req <= '0;
    end else if (coreIrqValid_ff) begin
      req <= '0;
    end else if (go) begin
      req <= '{valid: 1'h1, level: lvl, entry: ent};
    end
  end
endmodule
`default_nettype wire

// ==== dv/icsp_top_tb.sv ====
// Self-checking bench for the interrupt control, status and proximity block.
// Assumes the register map of the package and a core model on the request side.
`default_nettype none
module icsp_top_tb
  import icsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0;
  logic srst = 1'h1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic debugMode = 1'h0, go = 1'h0;
  logic [4:0] extLine = 5'h00;
  logic [2:0] lvl = 3'h0;
  logic [5:0] ent = 6'h00;
  logic awready, wready, bvalid, arready, rvalid, coreIrqValid_ff;
  logic coreShadow_ff, multiMode_ff, irqOut_ff;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] coreLevel_ff;
  logic [5:0] coreEntry_ff;
  logic [4:0] extEdge_ff;
  logic [4:0] acc;
  icsp_req_t req;
  int miscompares = 0;
  int comparisons = 0;
  int lat;

  // Free-running 40 MHz clock.
  always #12.5 ref_clk = ~ref_clk;

  icsp_top icsp_top_inst (.ref_clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .req, .debugMode, .extLine, .coreIrqValid_ff, .coreLevel_ff,
    .coreEntry_ff, .coreShadow_ff, .multiMode_ff, .extEdge_ff, .irqOut_ff);

  icsp_core_model icsp_core_model_inst (.ref_clk, .srst, .go, .lvl, .ent, .coreIrqValid_ff,
    .req);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic hang();
    miscompares++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    complete_run();
  endtask

  // Handshakes are sampled at the falling edge so that the combinational readies never race
  // the driving edge; the bench then acts on the following rising edge.
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, b;
    logic [1:0] r;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(negedge ref_clk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      b = bvalid;
      r = bresp;
      @(posedge ref_clk);
      if (ah) awvalid <= 1'h0;
      if (wh) wvalid <= 1'h0;
      if (b) begin
        bready <= 1'h0;
        chk(r, er);
        return;
      end
    end
    hang();
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ah, v;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(negedge ref_clk);
      ah = arvalid & arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge ref_clk);
      if (ah) arvalid <= 1'h0;
      if (v) begin
        rready <= 1'h0;
        chk({r, d}, {er, ed});
        return;
      end
    end
    hang();
  endtask

  task automatic issue(input logic [2:0] l, input logic [5:0] e);
    @(posedge ref_clk);
    lvl <= l;
    ent <= e;
    go <= 1'h1;
    @(posedge ref_clk);
    go <= 1'h0;
  endtask

  // Returns the number of falling edges until presentation, or -1 if none came.
  task automatic waitp(input int lim, output int l);
    l = -1;
    for (int n = 0; n < lim; n++) begin
      @(negedge ref_clk);
      if (coreIrqValid_ff === 1'h1) begin
        l = n;
        chk({coreLevel_ff, coreEntry_ff}, {lvl, ent});
        return;
      end
    end
  endtask

  task automatic edges(input logic [4:0] v);
    @(posedge ref_clk);
    extLine <= v;
    acc = 5'h00;
    repeat (10) begin
      @(negedge ref_clk);
      acc |= extEdge_ff;
    end
  endtask

  task automatic t_reset();
    axr(ADDR_CTRL, 32'h0, RESP_OKAY);
    axr(ADDR_STAT, 32'h0, RESP_OKAY);
    axr(ADDR_RELOAD, 32'h0, RESP_OKAY);
    chk({coreIrqValid_ff, multiMode_ff, coreShadow_ff, irqOut_ff, extEdge_ff}, 32'h0);
  endtask

  task automatic t_ctrl();
    axw(ADDR_CTRL, 32'hFFFF_FFFF, RESP_OKAY);
    axr(ADDR_CTRL, 32'h0001_171F, RESP_OKAY);
    repeat (2) @(negedge ref_clk);
    chk({multiMode_ff, coreShadow_ff}, 32'h2);
    axw(ADDR_CTRL, 32'h0001_0000, RESP_OKAY);
    repeat (2) @(negedge ref_clk);
    chk({multiMode_ff, coreShadow_ff}, 32'h1);
    axw(ADDR_STAT, 32'hFFFF_FFFF, RESP_OKAY);
    axr(ADDR_STAT, 32'h0, RESP_OKAY);
    axw(8'h20, 32'h1, RESP_SLVERR);
    axr(8'h20, 32'h0, RESP_SLVERR);
  endtask

  // The freeze must hold a pending request for as long as debug mode lasts.
  task automatic t_halt();
    @(posedge ref_clk);
    debugMode <= 1'h1;
    axw(ADDR_CTRL, 32'h0000_4000, RESP_OKAY);
    axr(ADDR_CTRL, 32'h0000_4000, RESP_OKAY);
    issue(3'h5, 6'h11);
    waitp(20, lat);
    chk(lat, -1);
    @(posedge ref_clk);
    debugMode <= 1'h0;
    waitp(20, lat);
    chk(lat >= 0, 1);
    axr(ADDR_CTRL, 32'h0, RESP_OKAY);
    @(posedge ref_clk);
    debugMode <= 1'h1;
    axw(ADDR_CTRL, 32'h0, RESP_OKAY);
    @(posedge ref_clk);
    debugMode <= 1'h0;
  endtask

  task automatic t_status();
    issue(3'h5, 6'h2A);
    waitp(20, lat);
    chk(lat < 4, 1);
    axr(ADDR_STAT, 32'h0000_052A, RESP_OKAY);
  endtask

  task automatic t_prox();
    axw(ADDR_RELOAD, 32'h8, RESP_OKAY);
    axr(ADDR_RELOAD, 32'h8, RESP_OKAY);
    axw(ADDR_CTRL, 32'h0000_0300, RESP_OKAY);
    issue(3'h3, 6'h01);
    waitp(100, lat);
    chk(lat >= 8 && lat < 100, 1);
    issue(3'h4, 6'h02);
    waitp(20, lat);
    chk(lat < 4, 1);
    axw(ADDR_CTRL, 32'h0000_0100, RESP_OKAY);
    issue(3'h2, 6'h03);
    waitp(20, lat);
    chk(lat < 4, 1);
    issue(3'h1, 6'h04);
    waitp(100, lat);
    chk(lat >= 8 && lat < 100, 1);
    axw(ADDR_CTRL, 32'h0, RESP_OKAY);
    issue(3'h1, 6'h05);
    waitp(20, lat);
    chk(lat < 4, 1);
    // Presentations and window expiries have been logged; no pin has moved yet.
    axr(ADDR_EVT, 32'h3, RESP_OKAY);
  endtask

  // Lines 0, 2 and 4 watch rising edges, lines 1 and 3 falling ones.
  task automatic t_ext();
    axw(ADDR_EVT_CLR, 32'h7F, RESP_OKAY);
    axw(ADDR_CTRL, 32'h15, RESP_OKAY);
    edges(5'h1F);
    chk(acc, 32'h15);
    axr(ADDR_EVT, 32'h54, RESP_OKAY);
    chk(irqOut_ff, 1'h0);
    axw(ADDR_EVT_EN, 32'h54, RESP_OKAY);
    repeat (3) @(negedge ref_clk);
    chk(irqOut_ff, 1'h1);
    axw(ADDR_EVT_EN, 32'h0, RESP_OKAY);
    repeat (3) @(negedge ref_clk);
    chk(irqOut_ff, 1'h0);
    axw(ADDR_EVT_EN, 32'h54, RESP_OKAY);
    axw(ADDR_EVT_CLR, 32'h7F, RESP_OKAY);
    repeat (3) @(negedge ref_clk);
    chk(irqOut_ff, 1'h0);
    axr(ADDR_EVT_CLR, 32'h0, RESP_OKAY);
    edges(5'h00);
    chk(acc, 32'h0A);
    axr(ADDR_EVT, 32'h28, RESP_OKAY);
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'h0;
    @(posedge ref_clk);
    t_reset();
    t_ctrl();
    t_halt();
    t_status();
    t_prox();
    t_ext();
    complete_run();
  end
endmodule
`default_nettype wire
